// >>> pkg/adc_path_pkg.sv
// Constants, field layouts and carriers for the ADC output path configuration block
package adc_path_pkg;

    // -------------------------------------------------------------------------
    // Widths
    // -------------------------------------------------------------------------
    localparam int SAMPLE_W  = 14;
    localparam int NUM_LINES = 4;
    localparam int MODE_W    = 3;
    localparam int GAIN_W    = 5;
    localparam int OFFSET_W  = 10;
    localparam int GAIN_LIN_W = 12;
    localparam int GAIN_FRAC = 10;
    localparam int APB_ADDR_W = 12;
    localparam int APB_DATA_W = 32;
    localparam int COUNT_W   = 16;

    // -------------------------------------------------------------------------
    // Register indices (byte address is four times the index)
    // -------------------------------------------------------------------------
    localparam logic [7:0] IDX_PATTERN = 8'h17;
    localparam logic [7:0] IDX_POWER   = 8'h18;
    localparam logic [7:0] IDX_CH5     = 8'h19;
    localparam logic [7:0] IDX_CONTROL = 8'h20;
    localparam logic [7:0] IDX_STATUS  = 8'h21;

    // -------------------------------------------------------------------------
    // Field positions
    // -------------------------------------------------------------------------
    localparam int LINE3_MODE_LSB  = 5;
    localparam int LINE4_MODE_LSB  = 2;
    localparam int PD_DIG_LSB      = 12;
    localparam int PD_LINE_LSB     = 8;
    localparam int PD_ANA_LSB      = 4;
    localparam int INVERT_LSB      = 0;
    localparam int GAIN_LSB        = 11;
    localparam int OFFSET_LSB      = 0;
    localparam int CTRL_IND_BIT    = 0;
    localparam int CTRL_GAIN_BIT   = 1;
    localparam int CTRL_OFFSET_BIT = 2;
    localparam int CTRL_CUSTOM_LSB = 16;
    localparam int STAT_VALID_BIT  = 0;
    localparam int STAT_FULL_BIT   = 1;
    localparam int STAT_COUNT_LSB  = 16;

    // -------------------------------------------------------------------------
    // Writable bit masks and reset values
    // -------------------------------------------------------------------------
    localparam logic [31:0] PATTERN_MASK  = 32'h0000_00fc;
    localparam logic [31:0] POWER_MASK    = 32'h0000_ffff;
    localparam logic [31:0] CH5_MASK      = 32'h0000_fbff;
    localparam logic [31:0] CONTROL_MASK  = 32'h3fff_0007;
    localparam logic [31:0] PATTERN_RESET = 32'h0000_0000;
    localparam logic [31:0] POWER_RESET   = 32'h0000_0000;
    localparam logic [31:0] CH5_RESET     = 32'h0000_0000;
    localparam logic [31:0] CONTROL_RESET = 32'h0000_0000;

    // -------------------------------------------------------------------------
    // Pattern modes
    // -------------------------------------------------------------------------
    typedef enum logic [MODE_W-1:0] {
        MODE_NORMAL,
        MODE_SYNC,
        MODE_ALTERNATE,
        MODE_CUSTOM,
        MODE_ALL_ONES,
        MODE_TOGGLE,
        MODE_ALL_ZEROS,
        MODE_RAMP
    } pattern_mode_code_t;

    // -------------------------------------------------------------------------
    // Linear gain per 0.2 dB step, Q10
    // -------------------------------------------------------------------------
    localparam logic [GAIN_LIN_W-1:0] GAIN_UNITY = 12'h400;
    localparam logic [GAIN_LIN_W-1:0] GAIN_TABLE [32] = '{
        12'h400, 12'h418, 12'h430, 12'h449, 12'h463, 12'h47d, 12'h498, 12'h4b3,
        12'h4cf, 12'h4ec, 12'h509, 12'h527, 12'h546, 12'h565, 12'h585, 12'h5a6,
        12'h5c8, 12'h5eb, 12'h60e, 12'h632, 12'h657, 12'h67d, 12'h6a3, 12'h6cb,
        12'h6f4, 12'h71d, 12'h747, 12'h773, 12'h79f, 12'h7cd, 12'h7fb, 12'h82b
    };

    // -------------------------------------------------------------------------
    // Carriers
    // -------------------------------------------------------------------------
    typedef logic [SAMPLE_W-1:0] sample_t;

    typedef struct packed {
        sample_t [NUM_LINES-1:0] line;
        sample_t                 chan5;
    } in_frame_t;

    typedef struct packed {
        logic    [NUM_LINES-1:0] line_on;
        sample_t [NUM_LINES-1:0] line;
        sample_t                 chan5;
    } out_frame_t;

    typedef struct packed {
        logic [NUM_LINES-1:0] digital;
        logic [NUM_LINES-1:0] line;
        logic [NUM_LINES-1:0] analog;
    } powerdown_t;

endpackage : adc_path_pkg

// >>> rtl/two_entry_buffer.sv
// Small flip-flop FIFO with valid and ready on both sides
`timescale 1ns/1ps
module two_entry_buffer #(
    parameter int WIDTH = 8,
    parameter int DEPTH = 2
) (
    // Clock and reset
    input  wire logic             ref_clk,
    input  wire logic             rstn,
    // Fill side
    input  wire logic             in_valid,
    output logic                  in_ready,
    input  wire logic [WIDTH-1:0] in_data,
    // Drain side
    output logic                  out_valid,
    input  wire logic             out_ready,
    output logic [WIDTH-1:0]      out_data,
    output logic                  full
);
    localparam int PTR_W = (DEPTH > 1) ? $clog2(DEPTH) : 1;
    localparam int CNT_W = $clog2(DEPTH + 1);
    localparam logic [PTR_W-1:0] LAST  = PTR_W'(DEPTH - 1);
    localparam logic [CNT_W-1:0] LIMIT = CNT_W'(DEPTH);

    logic [WIDTH-1:0] mem [DEPTH];
    logic [PTR_W-1:0] wr_ptr;
    logic [PTR_W-1:0] rd_ptr;
    logic [CNT_W-1:0] count;

    wire push = in_valid & in_ready;
    wire pop  = out_valid & out_ready;

    assign in_ready  = (count != LIMIT);
    assign out_valid = (count != '0);
    assign full      = (count == LIMIT);
    assign out_data  = mem[rd_ptr];

    always_ff @(posedge ref_clk or negedge rstn) begin
        if (!rstn) begin
            wr_ptr <= '0;
            rd_ptr <= '0;
            count  <= '0;
        end else begin
            if (push) begin
                wr_ptr <= (wr_ptr == LAST) ? '0 : wr_ptr + 1'b1;
            end
            if (pop) begin
                rd_ptr <= (rd_ptr == LAST) ? '0 : rd_ptr + 1'b1;
            end
            if (push && !pop) begin
                count <= count + 1'b1;
            end else if (pop && !push) begin
                count <= count - 1'b1;
            end
        end
    end

    always_ff @(posedge ref_clk or negedge rstn) begin
        if (!rstn) begin
            for (int i = 0; i < DEPTH; i++) begin
                mem[i] <= '0;
            end
        end else if (push) begin
            mem[wr_ptr] <= in_data;
        end
    end

endmodule : two_entry_buffer

// >>> rtl/line_pattern_gen.sv
// Test pattern source for one serial output line
`timescale 1ns/1ps
module line_pattern_gen #(
    parameter int W = 14
) (
    // Clock and reset
    input  wire logic         ref_clk,
    input  wire logic         rstn,
    // Control
    input  wire logic         enable,
    input  wire logic [2:0]   mode,
    input  wire logic [W-1:0] custom,
    input  wire logic         advance,
    // Data
    input  wire logic [W-1:0] data_in,
    output logic [W-1:0]      data_out
);
    localparam int H = W / 2;
    localparam logic [W-1:0] SYNC_WORD = {{(W - H){1'b1}}, {H{1'b0}}};
    localparam logic [W-1:0] TOGGLE_A  = W'({(W / 2 + 1){2'b01}});

    logic         phase;
    logic [W-1:0] ramp;
    logic [W-1:0] pattern;

    always_ff @(posedge ref_clk or negedge rstn) begin
        if (!rstn) begin
            phase <= 1'b0;
            ramp  <= '0;
        end else if (advance) begin
            phase <= ~phase;
            ramp  <= ramp + 1'b1;
        end
    end

    // Mode decode
    always_comb begin
        case (adc_path_pkg::pattern_mode_code_t'(mode))
            adc_path_pkg::MODE_NORMAL:    pattern = data_in;
            adc_path_pkg::MODE_SYNC:      pattern = SYNC_WORD;
            adc_path_pkg::MODE_ALTERNATE: pattern = phase ? '1 : '0;
            adc_path_pkg::MODE_CUSTOM:    pattern = custom;
            adc_path_pkg::MODE_ALL_ONES:  pattern = '1;
            adc_path_pkg::MODE_TOGGLE:    pattern = phase ? ~TOGGLE_A : TOGGLE_A;
            adc_path_pkg::MODE_ALL_ZEROS: pattern = '0;
            adc_path_pkg::MODE_RAMP:      pattern = ramp;
            default:                      pattern = data_in;
        endcase
    end

    assign data_out = enable ? pattern : data_in;

endmodule : line_pattern_gen

// >>> rtl/adc_output_path_config.sv
// APB register bank and output data path of the ADC serial output stage
//
// Behaviour
// - Three-bit code picks line output content
// - Line 3 mode from bits 7-5
// - Line 4 mode from bits 4-2
// - Bits 15-12 power down channel digital blocks
// - Bits 11-8 power down output lines
// - Bits 7-4 power down channel analog blocks
// - Bits 3-0 invert output line data
// - Channel 5 gain N times 0.2 dB
// - Channel 5 ten-bit signed offset added
// - Registers at indices 17h, 18h, 19h
//
// Register access over APB was left to the implementer.
`timescale 1ns/1ps
module adc_output_path_config (
    // Clock and reset
    input  wire logic                                  ref_clk,
    input  wire logic                                  rstn,
    // APB slave
    input  wire logic                                  psel,
    input  wire logic                                  penable,
    input  wire logic                                  pwrite,
    input  wire logic [adc_path_pkg::APB_ADDR_W-1:0]   paddr,
    input  wire logic [adc_path_pkg::APB_DATA_W-1:0]   pwdata,
    input  wire logic [3:0]                            pstrb,
    output logic [adc_path_pkg::APB_DATA_W-1:0]        prdata,
    output logic                                       pready,
    output logic                                       pslverr,
    // Sample stream from the converters
    input  wire logic                                  in_valid,
    output logic                                       in_ready,
    input  wire adc_path_pkg::in_frame_t               in_frame,
    // Sample stream to the serial receiver
    output logic                                       out_valid,
    input  wire logic                                  out_ready,
    output adc_path_pkg::out_frame_t                   out_frame,
    // Power control levels
    output adc_path_pkg::powerdown_t                   powerdown
);
    localparam int SW  = adc_path_pkg::SAMPLE_W;
    localparam int NL  = adc_path_pkg::NUM_LINES;
    localparam int MW  = adc_path_pkg::MODE_W;
    localparam int OW  = adc_path_pkg::OFFSET_W;
    localparam int GW  = adc_path_pkg::GAIN_W;
    localparam int LW  = adc_path_pkg::GAIN_LIN_W;
    localparam int CW  = adc_path_pkg::COUNT_W;
    localparam int OUT_W = $bits(adc_path_pkg::out_frame_t);

    // -------------------------------------------------------------------------
    // Register storage
    // -------------------------------------------------------------------------
    logic [31:0] pattern_select_lines_3_4;
    logic [31:0] power_and_inversion_control;
    logic [31:0] channel5_gain_offset;
    logic [31:0] output_path_control;
    logic [CW-1:0] frame_count;

    // -------------------------------------------------------------------------
    // APB decode
    // -------------------------------------------------------------------------
    wire       setup_phase  = psel & ~penable;
    wire       access_phase = psel & penable;
    wire [7:0] reg_index    = paddr[9:2];
    wire       aligned      = (paddr[1:0] == 2'h0) && (paddr[11:10] == 2'h0);

    wire hit_pattern = aligned && (reg_index == adc_path_pkg::IDX_PATTERN);
    wire hit_power   = aligned && (reg_index == adc_path_pkg::IDX_POWER);
    wire hit_ch5     = aligned && (reg_index == adc_path_pkg::IDX_CH5);
    wire hit_control = aligned && (reg_index == adc_path_pkg::IDX_CONTROL);
    wire hit_status  = aligned && (reg_index == adc_path_pkg::IDX_STATUS);
    wire mapped      = hit_pattern | hit_power | hit_ch5 | hit_control | hit_status;
    wire write_now   = access_phase & pwrite & mapped;

    wire [31:0] lane_mask = {{8{pstrb[3]}}, {8{pstrb[2]}}, {8{pstrb[1]}}, {8{pstrb[0]}}};

    function automatic logic [31:0] merge(input logic [31:0] old_value,
                                          input logic [31:0] new_value,
                                          input logic [31:0] lanes,
                                          input logic [31:0] field_mask);
        merge = ((old_value & ~lanes) | (new_value & lanes)) & field_mask;
    endfunction : merge

    wire [31:0] next_pattern = merge(pattern_select_lines_3_4, pwdata, lane_mask,
                                     adc_path_pkg::PATTERN_MASK);
    wire [31:0] next_power   = merge(power_and_inversion_control, pwdata, lane_mask,
                                     adc_path_pkg::POWER_MASK);
    wire [31:0] next_ch5     = merge(channel5_gain_offset, pwdata, lane_mask,
                                     adc_path_pkg::CH5_MASK);
    wire [31:0] next_control = merge(output_path_control, pwdata, lane_mask,
                                     adc_path_pkg::CONTROL_MASK);

    // -------------------------------------------------------------------------
    // Register writes
    // -------------------------------------------------------------------------
    always_ff @(posedge ref_clk or negedge rstn) begin
        if (!rstn) begin
            pattern_select_lines_3_4    <= adc_path_pkg::PATTERN_RESET;
            power_and_inversion_control <= adc_path_pkg::POWER_RESET;
            channel5_gain_offset        <= adc_path_pkg::CH5_RESET;
            output_path_control         <= adc_path_pkg::CONTROL_RESET;
        end else if (write_now) begin
            if (hit_pattern) pattern_select_lines_3_4    <= next_pattern;
            if (hit_power)   power_and_inversion_control <= next_power;
            if (hit_ch5)     channel5_gain_offset        <= next_ch5;
            if (hit_control) output_path_control         <= next_control;
        end
    end

    // -------------------------------------------------------------------------
    // Field extraction
    // -------------------------------------------------------------------------
    wire independent_pattern_enable = output_path_control[adc_path_pkg::CTRL_IND_BIT];
    wire global_gain_enable         = output_path_control[adc_path_pkg::CTRL_GAIN_BIT];
    wire global_offset_enable       = output_path_control[adc_path_pkg::CTRL_OFFSET_BIT];
    wire [SW-1:0] custom_pattern    = output_path_control[adc_path_pkg::CTRL_CUSTOM_LSB +: SW];

    wire [MW-1:0] line3_pattern_mode =
        pattern_select_lines_3_4[adc_path_pkg::LINE3_MODE_LSB +: MW];
    wire [MW-1:0] line4_pattern_mode =
        pattern_select_lines_3_4[adc_path_pkg::LINE4_MODE_LSB +: MW];

    wire [NL-1:0] digital_pd  = power_and_inversion_control[adc_path_pkg::PD_DIG_LSB +: NL];
    wire [NL-1:0] line_pd     = power_and_inversion_control[adc_path_pkg::PD_LINE_LSB +: NL];
    wire [NL-1:0] analog_pd   = power_and_inversion_control[adc_path_pkg::PD_ANA_LSB +: NL];
    wire [NL-1:0] line_invert = power_and_inversion_control[adc_path_pkg::INVERT_LSB +: NL];

    wire [GW-1:0] chan5_digital_gain   = channel5_gain_offset[adc_path_pkg::GAIN_LSB +: GW];
    wire [OW-1:0] chan5_digital_offset = channel5_gain_offset[adc_path_pkg::OFFSET_LSB +: OW];

    assign powerdown.digital = digital_pd;
    assign powerdown.line    = line_pd;
    assign powerdown.analog  = analog_pd;

    // -------------------------------------------------------------------------
    // Stream handshake
    // -------------------------------------------------------------------------
    wire advance = in_valid & in_ready;
    logic buffer_full;

    always_ff @(posedge ref_clk or negedge rstn) begin
        if (!rstn) begin
            frame_count <= '0;
        end else if (advance) begin
            frame_count <= frame_count + 1'b1;
        end
    end

    // -------------------------------------------------------------------------
    // Per-line processing
    // -------------------------------------------------------------------------
    adc_path_pkg::out_frame_t proc_frame;

    for (genvar i = 0; i < NL; i++) begin : g_line
        wire [SW-1:0] powered  = (digital_pd[i] | analog_pd[i]) ? '0 :
                                 in_frame.line[i];
        wire [SW-1:0] patterned;
        if (i >= 2) begin : g_pat
            line_pattern_gen #(
                .W (SW)
            ) u_pattern (
                .ref_clk  (ref_clk),
                .rstn     (rstn),
                .enable   (independent_pattern_enable),
                .mode     (i == 2 ? line3_pattern_mode : line4_pattern_mode),
                .custom   (custom_pattern),
                .advance  (advance),
                .data_in  (powered),
                .data_out (patterned)
            );
        end else begin : g_pass
            assign patterned = powered;
        end
        wire [SW-1:0] inverted = line_invert[i] ? ~patterned : patterned;
        assign proc_frame.line[i]    = line_pd[i] ? '0 : inverted;
        assign proc_frame.line_on[i] = ~line_pd[i];
    end

    // -------------------------------------------------------------------------
    // Channel 5 offset and gain
    // -------------------------------------------------------------------------
    wire signed [SW:0] chan5_ext   = $signed({in_frame.chan5[SW-1], in_frame.chan5});
    wire signed [SW:0] offset_ext  = $signed({{(SW + 1 - OW){chan5_digital_offset[OW-1]}},
                                              chan5_digital_offset});
    wire signed [SW:0] offset_term = global_offset_enable ? offset_ext : '0;
    wire signed [SW:0] offset_sum  = chan5_ext + offset_term;

    wire [LW-1:0] gain_linear = global_gain_enable ?
                                adc_path_pkg::GAIN_TABLE[chan5_digital_gain] :
                                adc_path_pkg::GAIN_UNITY;

    wire signed [SW+LW+1:0] product = offset_sum * $signed({1'b0, gain_linear});
    wire signed [SW+3:0]   scaled  = product[adc_path_pkg::GAIN_FRAC +: SW + 4];
    wire [4:0]             top     = scaled[SW+3:SW-1];
    wire                   overflow = ~(&top) & (|top);
    wire [SW-1:0]          saturated = scaled[SW+3] ? {1'b1, {(SW - 1){1'b0}}} :
                                                      {1'b0, {(SW - 1){1'b1}}};

    assign proc_frame.chan5 = overflow ? saturated : scaled[SW-1:0];

    // -------------------------------------------------------------------------
    // Output buffer
    // -------------------------------------------------------------------------
    logic [OUT_W-1:0] buffer_out;

    two_entry_buffer #(
        .WIDTH (OUT_W),
        .DEPTH (2)
    ) u_buffer (
        .ref_clk   (ref_clk),
        .rstn      (rstn),
        .in_valid  (in_valid),
        .in_ready  (in_ready),
        .in_data   (proc_frame),
        .out_valid (out_valid),
        .out_ready (out_ready),
        .out_data  (buffer_out),
        .full      (buffer_full)
    );

    assign out_frame = adc_path_pkg::out_frame_t'(buffer_out);

    // -------------------------------------------------------------------------
    // Read path
    // -------------------------------------------------------------------------
    wire [31:0] status_word = {frame_count, {(adc_path_pkg::STAT_COUNT_LSB - 2){1'b0}},
                               buffer_full, out_valid};

    wire [31:0] read_mux = hit_pattern ? pattern_select_lines_3_4    :
                           hit_power   ? power_and_inversion_control :
                           hit_ch5     ? channel5_gain_offset        :
                           hit_control ? output_path_control         :
                           hit_status  ? status_word                 : 32'h0000_0000;

    always_ff @(posedge ref_clk or negedge rstn) begin
        if (!rstn) begin
            prdata <= '0;
        end else if (setup_phase) begin
            prdata <= pwrite ? 32'h0000_0000 : read_mux;
        end
    end

    assign pready  = 1'b1;
    assign pslverr = access_phase & ~mapped;

endmodule : adc_output_path_config

// >>> sim/adc_output_path_config_assertions.sv
// Checker for the ADC output path register bank
`timescale 1ns/1ps
module adc_path_checker (
    // Clock and reset
    input wire logic                     ref_clk,
    input wire logic                     rstn,
    // APB
    input wire logic                     psel,
    input wire logic                     penable,
    input wire logic                     pwrite,
    input wire logic [11:0]              paddr,
    input wire logic [31:0]              pwdata,
    input wire logic [31:0]              prdata,
    input wire logic                     pslverr,
    // Stream out and power levels
    input wire logic                     out_valid,
    input wire adc_path_pkg::out_frame_t out_frame,
    input wire adc_path_pkg::powerdown_t powerdown
);
    // -------------------------------------------------------------------------
    // Decode
    // -------------------------------------------------------------------------
    default clocking @(posedge ref_clk); endclocking
    default disable iff (!rstn);
    wire acc = psel && penable;
    wire pw  = acc && pwrite && paddr == 12'h060;
    wire al  = paddr[11:10] == 2'h0 && paddr[1:0] == 2'h0;
    wire hit = al && paddr[9:2] inside {8'h17, 8'h18, 8'h19};
    wire kn  = hit || (al && paddr[9:2] inside {8'h20, 8'h21});

    dig_pd_a: assert property (pw |=> powerdown.digital == $past(pwdata[15:12]))
        else $error("digital powerdown not taken");
    line_pd_a: assert property (pw |=> powerdown.line == $past(pwdata[11:8]))
        else $error("line powerdown not taken");
    ana_pd_a: assert property (pw |=> powerdown.analog == $past(pwdata[7:4]))
        else $error("analog powerdown not taken");
    pd_hold_a: assert property (!$stable(powerdown) |-> $past(pw))
        else $error("powerdown moved without a write");
    line_off_a: assert property (out_valid & !out_frame.line_on[3] |-> !out_frame.line[3])
        else $error("powered down line carries data");
    err_map_a: assert property (acc && !kn |-> pslverr)
        else $error("unmapped access not refused");
    hit_map_a: assert property (acc && hit |-> !pslverr)
        else $error("mapped access refused");
    rd_zero_a: assert property (acc && !pwrite && !kn |-> prdata == 32'h0)
        else $error("unmapped read not zero");
endmodule : adc_path_checker

bind adc_output_path_config adc_path_checker i_chk (.ref_clk, .rstn, .psel, .penable, .pwrite,
    .paddr, .pwdata, .prdata, .pslverr, .out_valid, .out_frame, .powerdown);

// >>> sim/lvds_rx_model.sv
// Receiver model taking frames from the serial output stream
`timescale 1ns/1ps
module lvds_rx_model (
    // Clock and reset
    input wire logic ref_clk,
    input wire logic rstn,
    // Flow control
    input wire logic hold,
    input wire logic slow,
    output logic     out_ready
);
    // Stalls at random when slow, takes nothing while held
    always_ff @(posedge ref_clk or negedge rstn)
        if (!rstn) out_ready <= 1'b0;
        else out_ready <= !hold && (!slow || $urandom_range(0, 3) == 0);
endmodule : lvds_rx_model

// >>> sim/test_adc_output_path_config.sv
// Self-checking bench for the ADC output path register bank
`timescale 1ns/1ps
module test_adc_output_path_config;
    logic ref_clk = 0, rstn = 0, psel = 0, penable = 0, pwrite = 0, in_valid = 0;
    logic hold = 1, slow = 0, pready, pslverr, in_ready, out_valid, out_ready, er;
    logic [11:0] paddr = 12'h0;
    logic [3:0] pstrb = 4'hf;
    logic [31:0] pwdata = 32'h0, prdata, rd, pat = 32'h0, pwr = 32'h0, ctl = 32'h0, ch5 = 32'h0;
    adc_path_pkg::in_frame_t in_frame = '0, f;
    adc_path_pkg::out_frame_t out_frame, e_q[$];
    adc_path_pkg::powerdown_t powerdown;
    int failures = 0, tests_run = 0, cyc = 0, k = 0;

    always #20 ref_clk = ~ref_clk;

    adc_output_path_config i_dut (.ref_clk, .rstn, .psel, .penable, .pwrite, .paddr, .pwdata,
        .pstrb, .prdata, .pready, .pslverr, .in_valid, .in_ready, .in_frame, .out_valid,
        .out_ready, .out_frame, .powerdown);
    lvds_rx_model i_rx (.ref_clk, .rstn, .hold, .slow, .out_ready);

    // -------------------------------------------------------------------------
    // Tasks
    // -------------------------------------------------------------------------
    task automatic check(string name, logic [79:0] seen, logic [79:0] exp);
        tests_run++;
        if (seen !== exp) begin
            failures++;
            $display("Error %s expected %h seen %h", name, exp, seen);
        end
    endtask : check

    task automatic print_verdict();
        $display("Comparisons %0d mismatches %0d", tests_run, failures);
        if (failures == 0 && tests_run > 0)
            $display("All checks passed");
        else
            $display("Checks failed");
        $finish;
    endtask : print_verdict

    task automatic reset();
        @(posedge ref_clk);
        rstn <= 0;
        repeat (6) @(posedge ref_clk);
        rstn <= 1;
        k = 0;
    endtask : reset

    task automatic apb(logic w, logic [11:0] a, logic [31:0] d);
        @(posedge ref_clk);
        psel <= 1;
        pwrite <= w;
        paddr <= a;
        pwdata <= d;
        @(posedge ref_clk);
        penable <= 1;
        do @(posedge ref_clk); while (pready !== 1'b1);
        rd = prdata;
        er = pslverr;
        psel <= 0;
        penable <= 0;
    endtask : apb

    task automatic rdchk(logic [11:0] a, logic [31:0] x, logic e);
        apb(0, a, 32'h0);
        check("prdata", rd, x);
        check("pslverr", er, e);
    endtask : rdchk

    function automatic adc_path_pkg::out_frame_t model(adc_path_pkg::in_frame_t fi, int n);
        adc_path_pkg::out_frame_t fo;
        logic [13:0] v;
        logic [2:0] m;
        int s;
        for (int i = 0; i < 4; i++) begin
            v = (pwr[12+i] | pwr[4+i]) ? 14'h0 : fi.line[i];
            m = i == 2 ? pat[7:5] : pat[4:2];
            if (ctl[0] && i > 1)
                case (m)
                    1: v = 14'h3f80;
                    2: v = n[0] ? 14'h3fff : 14'h0;
                    3: v = ctl[29:16];
                    4: v = 14'h3fff;
                    5: v = n[0] ? 14'h2aaa : 14'h1555;
                    6: v = 14'h0;
                    7: v = n[13:0];
                    default: ;
                endcase
            fo.line[i] = pwr[8+i] ? 14'h0 : pwr[i] ? ~v : v;
            fo.line_on[i] = !pwr[8+i];
        end
        s = $signed(fi.chan5) + (ctl[2] ? $signed(ch5[9:0]) : 0);
        s = s * (ctl[1] ? int'(adc_path_pkg::GAIN_TABLE[ch5[15:11]]) : 1024) >>> 10;
        fo.chan5 = s > 8191 ? 14'h1fff : s < -8192 ? 14'h2000 : s[13:0];
        return fo;
    endfunction : model

    task automatic send(int cnt);
        logic [95:0] r;
        repeat (cnt) begin
            r = {$urandom, $urandom, $urandom};
            f = r[69:0];
            e_q.push_back(model(f, k));
            k++;
            in_frame <= f;
            in_valid <= 1;
            do @(posedge ref_clk); while (in_ready !== 1'b1);
        end
        in_valid <= 0;
    endtask : send

    // -------------------------------------------------------------------------
    // Output watch and timeout
    // -------------------------------------------------------------------------
    always @(posedge ref_clk)
        if (rstn && out_valid === 1'b1 && out_ready === 1'b1) begin
            if (e_q.size() == 0) check("spare frame", 1, 0);
            else check("out_frame", out_frame, e_q.pop_front());
        end

    always @(posedge ref_clk)
        if (++cyc == 5000) begin
            failures++;
            print_verdict();
        end

    initial begin
        k = $urandom(91283);
        reset();
        rdchk(12'h05c, 32'h0, 0);
        rdchk(12'h060, 32'h0, 0);
        rdchk(12'h064, 32'h0, 0);
        send(2);
        #1 check("in_ready", in_ready, 0);
        hold <= 0;
        rdchk(12'h068, 32'h0, 1);
        rdchk(12'h061, 32'h0, 1);
        $display("Test reset, fill and map done");
        for (int m = 0; m < 8; m++) begin
            wait (e_q.size() == 0);
            reset();
            ctl = $urandom & 32'h3fff_0006 | 32'h1;
            pat = m << 5 | (7 - m) << 2;
            pwr = $urandom & $urandom & 32'hffff;
            ch5 = $urandom & 32'hfbff;
            apb(1, 12'h080, ctl);
            apb(1, 12'h05c, pat);
            apb(1, 12'h060, pwr);
            apb(1, 12'h064, ch5);
            apb(1, 12'h068, ch5 & 32'h3ff);
            rdchk(12'h05c, pat, 0);
            rdchk(12'h060, pwr, 0);
            rdchk(12'h064, ch5, 0);
            check("powerdown", powerdown, pwr[15:4]);
            slow <= m[0];
            send(3);
            $display("Test pattern mode %0d done", m);
        end
        wait (e_q.size() == 0);
        print_verdict();
    end
endmodule : test_adc_output_path_config
